//--- hw/dslp_host.sv
// host end: serialises 16-bit words, msb first, clock made by divider
// assumes send_valid/send_word from logic on clock
`timescale 1ns/1ps
module dslp_host #(
    parameter int unsigned DIV = dslp_pkg::CLK_DIV
) (
    // system
    input  wire logic                       clock,
    input  wire logic                       srst,
    // link
    dslp_if.host                            link,
    // request
    input  wire logic                       send_valid,
    input  wire logic [dslp_pkg::WORD_BITS-1:0] send_word,
    output logic                            send_ready,
    // readback
    output logic [dslp_pkg::WORD_BITS-1:0]  rb_word,
    output logic                            rb_valid
);
    import dslp_pkg::*;

    typedef enum logic [1:0] {DSLP_IDLE, DSLP_SETUP, DSLP_SHIFT, DSLP_GAP} dslp_state_t;

    dslp_state_t          st_q;
    logic [7:0]           div_q;
    logic [4:0]           half_q;
    logic [WORD_BITS-1:0] word_q;
    logic [WORD_BITS-1:0] rbs_q;
    logic [WORD_BITS-1:0] rb_word_q;
    logic                 rb_valid_q;
    logic                 sclk_q;
    logic                 sel_n_q;
    logic                 tick;

    assign tick       = (div_q == 8'(DIV - 1));
    assign send_ready = (st_q == DSLP_IDLE);

    always_ff @(posedge clock) begin
        if (srst || st_q == DSLP_IDLE || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q    <= DSLP_IDLE;
            sel_n_q <= 1'b1;
            sclk_q  <= 1'b1;
            half_q  <= 5'h00;
        end else begin
            unique case (st_q)
                DSLP_IDLE: begin
                    if (send_valid) begin
                        st_q    <= DSLP_SETUP;
                        sel_n_q <= 1'b0;
                        half_q  <= 5'h00;
                    end
                end
                DSLP_SETUP: begin
                    if (tick) begin
                        st_q   <= DSLP_SHIFT;
                        half_q <= 5'h00;
                    end
                end
                DSLP_SHIFT: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                        half_q <= half_q + 5'h01;
                        // one frame for all 16 bits
                        if (half_q == 5'(2 * WORD_BITS - 1)) begin
                            st_q <= DSLP_GAP;
                        end
                    end
                end
                DSLP_GAP: begin
                    if (tick) begin
                        sel_n_q <= 1'b1;
                        st_q    <= DSLP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            word_q <= RST_WORD;
        end else if (st_q == DSLP_IDLE && send_valid) begin
            word_q <= send_word;
        end else if (st_q == DSLP_SHIFT && tick && !sclk_q && half_q != 5'h00) begin
            word_q <= {word_q[WORD_BITS-2:0], 1'b0};
        end
    end

    // readback sampled on falling edge of link clock
    always_ff @(posedge clock) begin
        if (srst) begin
            rbs_q      <= RST_WORD;
            rb_word_q  <= RST_WORD;
            rb_valid_q <= 1'b0;
        end else begin
            rb_valid_q <= 1'b0;
            if (st_q == DSLP_SHIFT && tick && sclk_q) begin
                rbs_q <= {rbs_q[WORD_BITS-2:0], link.serial_readback_out};
            end
            if (st_q == DSLP_GAP && tick) begin
                rb_word_q  <= rbs_q;
                rb_valid_q <= 1'b1;
            end
        end
    end

    assign link.link_clk    = sclk_q;
    assign link.frame_sel_n = sel_n_q;
    assign link.serial_data = word_q[WORD_BITS-1];
    assign rb_word          = rb_word_q;
    assign rb_valid         = rb_valid_q;
endmodule : dslp_host

//--- hw/dslp_pkg.sv
// constants shared by both ends of the dac serial load port
// assumes the host and device meet through dslp_if
// Function
// - three host wires: clock, data, frame select
// - one 16-bit word per low frame
// - device samples data on falling clock
// - one bit shifted per falling edge
// - frame rise loads word into dac register
// - host sends most significant bit first
// - host changes data on rising edges
// - host lowers frame select before clocking
// - frame stays low across byte halves
// - frame rises only after all bits
// - readback shifts out on rising edges
package dslp_pkg;
    localparam int unsigned WORD_BITS   = 16;
    localparam int unsigned BYTE_BITS   = 8;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam int unsigned CLK_DIV     = 4;
    localparam int unsigned SETUP_HALFS = 2;
    localparam int unsigned GAP_HALFS   = 2;
    localparam int unsigned SYNC_STAGES = 3;
endpackage : dslp_pkg

//--- hw/dslp_if.sv
// three-wire load link plus readback line
// assumes the bench observes the host link and drives the second link itself
`timescale 1ns/1ps
interface dslp_if;
    logic link_clk;
    logic serial_data;
    logic frame_sel_n;
    logic serial_readback_out;

    modport host (
        output link_clk,
        output serial_data,
        output frame_sel_n,
        input  serial_readback_out
    );
    modport dev (
        input  link_clk,
        input  serial_data,
        input  frame_sel_n,
        output serial_readback_out
    );
endinterface : dslp_if

//--- hw/dslp_device.sv
// device end: input shift register, dac register, readback
// assumes link clock idles high between frames; srst synchronous to clock
`timescale 1ns/1ps
module dslp_device (
    // system side
    input  wire logic                       clock,
    input  wire logic                       srst,
    // link
    dslp_if.dev                             link,
    // user side
    output logic [dslp_pkg::WORD_BITS-1:0]  dac_value,
    output logic                            dac_update
);
    import dslp_pkg::*;

    // link domain has no reset: start from the cleared word
    logic [WORD_BITS-1:0] shift_q    = RST_WORD;
    logic [WORD_BITS-1:0] dac_word_q = RST_WORD;
    logic                 load_tgl_q = 1'b0;
    logic                 rb_q       = 1'b0;
    logic                 sel_q;
    logic [2:0]           tgl_sync_q;
    logic                 tgl_seen_q;
    logic [WORD_BITS-1:0] dac_value_q;
    logic                 dac_update_q;

    always_ff @(negedge link.link_clk) begin
        if (!link.frame_sel_n) begin
            shift_q <= {shift_q[WORD_BITS-2:0], link.serial_data};
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (!link.frame_sel_n) begin
            rb_q <= shift_q[WORD_BITS-1];
        end
    end

    assign link.serial_readback_out = rb_q;

    always_ff @(posedge link.frame_sel_n) begin
        dac_word_q <= shift_q;
        load_tgl_q <= ~load_tgl_q;
    end

    // toggle crossing into system domain
    always_ff @(posedge clock) begin
        if (srst) begin
            tgl_sync_q <= 3'h0;
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_sync_q <= {tgl_sync_q[1:0], load_tgl_q};
            tgl_seen_q <= tgl_sync_q[2];
        end
    end

    assign sel_q = tgl_sync_q[2] ^ tgl_seen_q;

    // word is stable once toggle agreed
    always_ff @(posedge clock) begin
        if (srst) begin
            dac_value_q  <= RST_WORD;
            dac_update_q <= 1'b0;
        end else begin
            dac_update_q <= sel_q && (tgl_sync_q[2] == tgl_sync_q[1]);
            if (sel_q && (tgl_sync_q[2] == tgl_sync_q[1])) begin
                dac_value_q <= dac_word_q;
            end
        end
    end

    assign dac_value  = dac_value_q;
    assign dac_update = dac_update_q;
endmodule : dslp_device

//--- verification/dslp_assertions.sv
// checker for the dslp link wires, sampled on the system clock
// assumes host drives the link from clock and link_clk idles high
`timescale 1ns/1ps
module dslp_assertions (
    // system
    input wire logic clock,
    input wire logic srst,
    // link
    input wire logic link_clk,
    input wire logic serial_data,
    input wire logic frame_sel_n,
    input wire logic serial_readback_out
);
    logic [5:0] fall_cnt_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // falling link edges inside the frame
    always_ff @(posedge clock) begin
        if (srst || frame_sel_n) fall_cnt_q <= 6'h00;
        else if ($fell(link_clk)) fall_cnt_q <= fall_cnt_q + 6'h01;
    end
    property p_frame_bits; $rose(frame_sel_n) |-> fall_cnt_q == 6'h10; endproperty
    a_frame_bits: assert property (p_frame_bits) else $error("frame ended without 16 clocks");
    property p_idle_clk; frame_sel_n |-> link_clk; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("link clock moved outside frame");
    property p_setup; $fell(frame_sel_n) |-> link_clk [*2] ##[1:8] $fell(link_clk); endproperty
    a_setup: assert property (p_setup) else $error("no setup before first clock");
    property p_data_rise; $changed(serial_data) && !frame_sel_n |-> link_clk; endproperty
    a_data_rise: assert property (p_data_rise) else $error("data changed while clock low");
    property p_fall_stable; $fell(link_clk) |-> $stable(serial_data); endproperty
    a_fall_stable: assert property (p_fall_stable) else $error("data moved at falling edge");
    property p_readback; $changed(serial_readback_out) |-> link_clk; endproperty
    a_readback: assert property (p_readback) else $error("readback moved off rising edge");
    property p_frame_len; $fell(frame_sel_n) |-> ##[120:140] $rose(frame_sel_n); endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    property p_clk_low; $fell(link_clk) |-> !link_clk [*3]; endproperty
    a_clk_low: assert property (p_clk_low) else $error("link clock low half too short");
    c_frame: cover property ($rose(frame_sel_n));
    c_rb: cover property ($changed(serial_readback_out));
    c_fall: cover property ($fell(link_clk) && serial_data);
endmodule : dslp_assertions

//--- verification/tb_dac_serial_load_port.sv
// testbench: host and device joined by dslp_if, second device driven by bench
// assumes dslp_pkg, dslp_if, dslp_host, dslp_device compiled before
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb_dac_serial_load_port;
    import dslp_pkg::*;
    logic clock = 0, srst = 1, send_valid = 0, send_ready, rb_valid, dac_update, dac_update2;
    logic [15:0] send_word = 16'h0000, rb_word, dac_value, dac_value2, cap, prev, rb2;
    logic [15:0] corners [4] = '{16'h0000, 16'hFFFF, 16'h8001, 16'hA5A5};
    int num_errors = 0, check_count = 0, nb;
    dslp_if lk ();
    dslp_if lk2 ();
    always #5 clock = ~clock;
    dslp_host dslp_host_inst (.clock(clock), .srst(srst), .link(lk.host), .send_valid(send_valid),
        .send_word(send_word), .send_ready(send_ready), .rb_word(rb_word), .rb_valid(rb_valid));
    dslp_device dslp_device_inst (.clock(clock), .srst(srst), .link(lk.dev), .dac_value(dac_value),
        .dac_update(dac_update));
    dslp_device dslp_device2_inst (.clock(clock), .srst(srst), .link(lk2.dev), .dac_value(dac_value2),
        .dac_update(dac_update2));
    dslp_assertions dslp_assertions_inst (.clock(clock), .srst(srst), .link_clk(lk.link_clk),
        .serial_data(lk.serial_data), .frame_sel_n(lk.frame_sel_n),
        .serial_readback_out(lk.serial_readback_out));
    // wire capture at the device sampling edge
    always @(negedge lk.frame_sel_n) nb = 0;
    always @(negedge lk.link_clk) if (!lk.frame_sel_n) begin
        cap = {cap[14:0], lk.serial_data};
        nb++;
    end
    task complete_run;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // flag selector: 0 ready, 1 readback, 2 update, 3 second update
    function automatic logic pick(input int which);
        if (which == 0) return send_ready;
        if (which == 1) return rb_valid;
        if (which == 2) return dac_update;
        return dac_update2;
    endfunction : pick
    task automatic wait_for(input int n, input int which);
        int i;
        for (i = 0; i < n && pick(which) !== 1'b1; i++) @(posedge clock) #1;
        if (pick(which) !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_for
    task send(input logic [15:0] w);
        wait_for(50, 0);
        send_valid = 1;
        send_word = w;
        @(posedge clock) #1 send_valid = 0;
        wait_for(400, 1);
        `CHK("rb_word", prev, rb_word)
        `CHK("wire order", w, cap)
        `CHK("bit count", 16, nb)
        wait_for(20, 2);
        `CHK("dac_value", w, dac_value)
        prev = w;
    endtask : send
    // bench-made link, 6 ns period; sel high means a proper frame
    task link2(input logic [15:0] w, input logic sel);
        int i;
        lk2.frame_sel_n = !sel;
        #6;
        for (i = 15; i >= 0; i--) begin
            lk2.serial_data = w[i];
            // readback bit stands before each falling edge
            #3 rb2 = {rb2[14:0], lk2.serial_readback_out};
            lk2.link_clk = 0;
            #3 lk2.link_clk = 1;
        end
        #6 lk2.frame_sel_n = 1;
        lk2.serial_data = !w[0];
    endtask : link2
    initial begin
        lk2.link_clk = 1;
        lk2.frame_sel_n = 1;
        lk2.serial_data = 0;
        prev = 16'h0000;
        void'($urandom(32'h6bac7a9d));
        repeat (4) @(posedge clock);
        #1 srst = 0;
        `CHK("dac reset", 16'h0000, dac_value)
        foreach (corners[k]) send(corners[k]);
        repeat (6) send(16'($urandom));
        link2(16'h5A3C, 1'b0);
        repeat (10) @(posedge clock);
        `CHK("ignored frame", 16'h0000, dac_value2)
        link2(16'hC3A5, 1'b1);
        wait_for(20, 3);
        `CHK("bench frame", 16'hC3A5, dac_value2)
        `CHK("ignored readback", 16'h0000, rb2)
        link2(16'h3C5A, 1'b1);
        wait_for(20, 3);
        `CHK("bench readback", 16'hC3A5, rb2)
        `CHK("bench frame 2", 16'h3C5A, dac_value2)
        complete_run();
    end
endmodule : tb_dac_serial_load_port
